/* File: shared/pmic_opt_pkg.sv */
// Purpose: Constants and carriers for the fault-filter and device option bank
// Assumes: 50 MHz core clock, 1 us shared time base, SPI mode 0 frames
// Notes:   Times are held in microseconds, save TIME_BASE_NS and TRK_WAIT_MS, and scaled by the time base
package pmic_opt_pkg;

  // ==========================================================================
  // Register map
  localparam logic [9:0] CORE_DB_OFFSET = 10'h163;
  localparam logic [9:0] AON_DB_OFFSET  = 10'h164;
  localparam logic [9:0] OPT_A_OFFSET   = 10'h200;
  localparam logic [9:0] OPT_B_OFFSET   = 10'h201;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] OPT_A_WR_MASK  = 8'hF7;

  // ==========================================================================
  // Field positions (low bit of each field)
  localparam int CORE_SEV_UV_LSB  = 6;
  localparam int CORE_WARN_UV_LSB = 4;
  localparam int CORE_SEV_OV_LSB  = 2;
  localparam int CORE_WARN_OV_LSB = 0;
  localparam int AON_SEV_LSB      = 6;
  localparam int AON_WARN_LSB     = 4;
  localparam int SYS_MON_LSB      = 2;
  localparam int OVERTEMP_LSB     = 0;
  localparam int STBY_EXIT_BIT    = 7;
  localparam int KEYED_WR_BIT     = 6;
  localparam int REG4_MODE_BIT    = 5;
  localparam int REG3_MODE_BIT    = 4;
  localparam int SDO_HIZ_BIT      = 2;
  localparam int SAFE_POL_BIT     = 1;
  localparam int CRC_EN_BIT       = 0;
  localparam int TRK_HOLD_BIT     = 7;
  localparam int IRQ_OD_BIT       = 6;
  localparam int RST_DLY_LSB      = 4;
  localparam int CONV2_SS_LSB     = 2;
  localparam int CONV1_SS_LSB     = 0;

  // ==========================================================================
  // Timing
  localparam int CORE_CLK_HZ     = 50000000;
  localparam int TIME_BASE_NS    = 1000;
  localparam int US_TICK_CYCLES  = TIME_BASE_NS / (1000000000 / CORE_CLK_HZ);
  localparam int SEV_DB_US  [4]  = '{1, 5, 10, 25};
  localparam int WARN_DB_US [4]  = '{10, 25, 50, 100};
  localparam int OT_DB_US   [4]  = '{50, 100, 1000, 2500};
  localparam int RST_DLY_US [4]  = '{0, 1500, 2000, 5000};
  localparam int SS_STEP_US [4]  = '{10, 20, 40, 100};
  localparam int TRK_WAIT_MS     = 3;
  localparam int TRK_WAIT_US     = TRK_WAIT_MS * 1000;
  localparam int SS_STEPS        = 128;
  localparam int TIME_W          = 13;
  localparam int NUM_FAULTS      = 11;

  // ==========================================================================
  // Serial frame
  localparam int         FRAME_BITS = 24;
  localparam int         CRC_BITS   = 8;
  localparam logic [7:0] CRC_POLY   = 8'h07;
  localparam logic [7:0] CRC_INIT   = 8'hFF;

  typedef struct packed {
    logic       write;
    logic [9:0] addr;
    logic [4:0] spare;
    logic [7:0] data;
  } frame_s;

  typedef struct packed {
    logic       core_sev_uv;
    logic       core_warn_uv;
    logic       core_sev_ov;
    logic       core_warn_ov;
    logic       aon_sev;
    logic       aon_warn;
    logic [3:0] system_mon;
    logic       overtemp;
  } fault_s;

endpackage

/* File: verilog/pmic_option_bank.sv */
// Purpose: Option register bank with fault debounce, reset delay, soft start
// Assumes: Host reaches the registers over SPI mode 0 on its own clock
// Notes:   Option bits are quasi-static when read across the serial domain
`timescale 1ns/1ps
`default_nettype none

module pmic_option_bank #(
  parameter int TICK_CYCLES = pmic_opt_pkg::US_TICK_CYCLES
) (
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic                 spi_sclk,
  input  wire logic                 serial_select_pin_n,
  input  wire logic                 spi_mosi,
  output logic                      serial_data_out_pin,
  output logic                      serial_data_out_oe_n,
  input  wire pmic_opt_pkg::fault_s raw_fault,
  output pmic_opt_pkg::fault_s      fault_out,
  input  wire logic                 standby_request_pin_n,
  input  wire logic                 in_deep_low_power,
  output logic                      deep_exit_request,
  input  wire logic                 key_unlocked,
  output logic                      keyed_write_required,
  output logic                      reg4_linear_mode,
  output logic                      reg3_linear_mode,
  input  wire logic                 safe_state_active,
  output logic                      safe_state_pin,
  output logic                      crc_mode,
  output logic                      frame_error,
  output logic                      write_refused,
  input  wire logic                 tracker_enable,
  input  wire logic                 tracker_supply_uvlo,
  output logic                      tracker_start,
  input  wire logic                 irq_request,
  output logic                      irq_out_pin,
  output logic                      irq_out_oe_n,
  input  wire logic                 monitor_valid_input,
  output logic                      reset_out_pin_n,
  input  wire logic [1:0]           conv_enable,
  output logic [1:0][7:0]           conv_ss_level,
  output logic [1:0]                conv_ss_done
);

  localparam int FW = pmic_opt_pkg::FRAME_BITS + pmic_opt_pkg::CRC_BITS;
  localparam int NF = pmic_opt_pkg::NUM_FAULTS;
  localparam int TW = pmic_opt_pkg::TIME_W;

  typedef enum logic [2:0] {
    RST_HOLD = 3'b001,
    RST_WAIT = 3'b010,
    RST_DONE = 3'b100
  } rst_state_e;

  logic [7:0]    core_db_q;
  logic [7:0]    aon_db_q;
  logic [7:0]    opt_a_q;
  logic [7:0]    opt_b_q;
  logic [7:0]    rd_q;

  // ==========================================================================
  // Serial link domain
  logic [FW-1:0] shift_q;
  logic [5:0]    bit_cnt_q;
  logic          in_frame_q;
  logic          out_bit;

  always_ff @(posedge spi_sclk or posedge serial_select_pin_n) begin
    if (serial_select_pin_n) begin
      in_frame_q <= 1'b0;
    end else begin
      in_frame_q <= 1'b1;
    end
  end

  // Count restarts on a frame's first clock, so the frame stays for decode
  always_ff @(posedge spi_sclk) begin
    shift_q <= {shift_q[FW-2:0], spi_mosi};
    if (!in_frame_q) begin
      bit_cnt_q <= 6'h01;
    end else if (bit_cnt_q != 6'h3F) begin
      bit_cnt_q <= bit_cnt_q + 6'h01;
    end
  end

  // Previous frame's read value leads each frame, MSB first
  always_comb begin
    out_bit = 1'b0;
    if (!in_frame_q) begin
      out_bit = rd_q[7];
    end else if (bit_cnt_q < 6'h08) begin
      out_bit = rd_q[3'h7 - bit_cnt_q[2:0]];
    end
  end

  assign serial_data_out_pin  = out_bit;
  assign serial_data_out_oe_n = opt_a_q[pmic_opt_pkg::SDO_HIZ_BIT]
                                & serial_select_pin_n;

  // ==========================================================================
  // Input synchronisers
  localparam int SW = NF + 6;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic [NF-1:0] raw_s;
  logic          sel_n_s;
  logic          stby_n_s;
  logic          uvlo_s;
  logic          mon_valid_s;
  logic          trk_en_s;
  logic          deep_s;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync1_q <= {{NF{1'b0}}, 6'h30};
      sync2_q <= {{NF{1'b0}}, 6'h30};
    end else begin
      sync1_q <= {raw_fault, serial_select_pin_n, standby_request_pin_n,
                  tracker_supply_uvlo, monitor_valid_input, tracker_enable,
                  in_deep_low_power};
      sync2_q <= sync1_q;
    end
  end

  assign {raw_s, sel_n_s, stby_n_s, uvlo_s, mon_valid_s, trk_en_s, deep_s} =
    sync2_q;

  // ==========================================================================
  // Shared 1 us time base
  logic [15:0] pre_q;
  logic        tick_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pre_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (pre_q == 16'(TICK_CYCLES - 1)) begin
      pre_q  <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      pre_q  <= pre_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Frame decode on the end of select
  logic          sel_n_d1_q;
  logic          frame_end;
  pmic_opt_pkg::frame_s frm;
  logic [7:0]    crc_rx;
  logic          len_ok;
  logic          crc_ok;
  logic          is_secure;
  logic          wr_ok;

  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = pmic_opt_pkg::CRC_INIT;
    for (int i = 23; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ pmic_opt_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sel_n_d1_q <= 1'b1;
    end else begin
      sel_n_d1_q <= sel_n_s;
    end
  end

  assign frame_end = sel_n_s & ~sel_n_d1_q;
  assign crc_mode  = opt_a_q[pmic_opt_pkg::CRC_EN_BIT];

  always_comb begin
    frm    = pmic_opt_pkg::frame_s'(shift_q[pmic_opt_pkg::FRAME_BITS-1:0]);
    crc_rx = 8'h00;
    crc_ok = 1'b1;
    len_ok = (bit_cnt_q == 6'(pmic_opt_pkg::FRAME_BITS));
    if (crc_mode) begin
      frm    = pmic_opt_pkg::frame_s'(shift_q[FW-1:pmic_opt_pkg::CRC_BITS]);
      crc_rx = shift_q[pmic_opt_pkg::CRC_BITS-1:0];
      crc_ok = (crc8(frm) == crc_rx);
      len_ok = (bit_cnt_q == 6'(FW));
    end
  end

  assign is_secure = (frm.addr == pmic_opt_pkg::CORE_DB_OFFSET) ||
                     (frm.addr == pmic_opt_pkg::AON_DB_OFFSET);
  assign keyed_write_required = opt_a_q[pmic_opt_pkg::KEYED_WR_BIT];
  assign wr_ok = frame_end & len_ok & crc_ok & frm.write &
                 ~(is_secure & keyed_write_required & ~key_unlocked);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      frame_error   <= 1'b0;
      write_refused <= 1'b0;
    end else begin
      frame_error   <= frame_end & ~(len_ok & crc_ok);
      write_refused <= frame_end & len_ok & crc_ok & frm.write & is_secure
                       & keyed_write_required & ~key_unlocked;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      core_db_q <= pmic_opt_pkg::REG_RESET;
      aon_db_q  <= pmic_opt_pkg::REG_RESET;
      opt_a_q   <= pmic_opt_pkg::REG_RESET;
      opt_b_q   <= pmic_opt_pkg::REG_RESET;
    end else if (wr_ok) begin
      case (frm.addr)
        pmic_opt_pkg::CORE_DB_OFFSET: core_db_q <= frm.data;
        pmic_opt_pkg::AON_DB_OFFSET:  aon_db_q  <= frm.data;
        pmic_opt_pkg::OPT_A_OFFSET:
          opt_a_q <= frm.data & pmic_opt_pkg::OPT_A_WR_MASK;
        pmic_opt_pkg::OPT_B_OFFSET:   opt_b_q   <= frm.data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_q <= 8'h00;
    end else if (frame_end & len_ok & crc_ok & ~frm.write) begin
      case (frm.addr)
        pmic_opt_pkg::CORE_DB_OFFSET: rd_q <= core_db_q;
        pmic_opt_pkg::AON_DB_OFFSET:  rd_q <= aon_db_q;
        pmic_opt_pkg::OPT_A_OFFSET:   rd_q <= opt_a_q;
        pmic_opt_pkg::OPT_B_OFFSET:   rd_q <= opt_b_q;
        default:                      rd_q <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Fault debounce filters
  function automatic logic [TW-1:0] fault_limit(input int idx,
                                                input logic [7:0] cdb,
                                                input logic [7:0] adb);
    logic [TW-1:0] lim;
    lim = '0;
    case (idx)
      10: lim = TW'(pmic_opt_pkg::SEV_DB_US[cdb[7:6]]);
      9:  lim = TW'(pmic_opt_pkg::WARN_DB_US[cdb[5:4]]);
      8:  lim = TW'(pmic_opt_pkg::SEV_DB_US[cdb[3:2]]);
      7:  lim = TW'(pmic_opt_pkg::WARN_DB_US[cdb[1:0]]);
      6:  lim = TW'(pmic_opt_pkg::SEV_DB_US[adb[7:6]]);
      5:  lim = TW'(pmic_opt_pkg::WARN_DB_US[adb[5:4]]);
      0:  lim = TW'(pmic_opt_pkg::OT_DB_US[adb[1:0]]);
      default: lim = TW'(pmic_opt_pkg::WARN_DB_US[adb[3:2]]);
    endcase
    return lim;
  endfunction

  logic [NF-1:0] fault_q;

  for (genvar g = 0; g < NF; g++) begin : g_filt
    logic [TW-1:0] cnt_q;
    logic [TW-1:0] lim;

    assign lim = fault_limit(g, core_db_q, aon_db_q);

    always_ff @(posedge core_clk) begin
      if (reset) begin
        cnt_q      <= '0;
        fault_q[g] <= 1'b0;
      end else if (!raw_s[g]) begin
        cnt_q      <= '0;
        fault_q[g] <= 1'b0;
      end else begin
        if (tick_q && cnt_q < lim) begin
          cnt_q <= cnt_q + TW'(1);
        end
        fault_q[g] <= (cnt_q >= lim);
      end
    end
  end

  assign fault_out = pmic_opt_pkg::fault_s'(fault_q);

  // ==========================================================================
  // Device mode outputs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      deep_exit_request <= 1'b0;
      safe_state_pin    <= 1'b0;
      irq_out_pin       <= 1'b1;
      irq_out_oe_n      <= 1'b0;
    end else begin
      deep_exit_request <= opt_a_q[pmic_opt_pkg::STBY_EXIT_BIT] & deep_s
                           & ~stby_n_s;
      safe_state_pin    <= safe_state_active
                           ^ opt_a_q[pmic_opt_pkg::SAFE_POL_BIT];
      if (opt_b_q[pmic_opt_pkg::IRQ_OD_BIT]) begin
        irq_out_pin  <= 1'b0;
        irq_out_oe_n <= ~irq_request;
      end else begin
        irq_out_pin  <= ~irq_request;
        irq_out_oe_n <= 1'b0;
      end
    end
  end

  assign reg4_linear_mode = opt_a_q[pmic_opt_pkg::REG4_MODE_BIT];
  assign reg3_linear_mode = opt_a_q[pmic_opt_pkg::REG3_MODE_BIT];

  // ==========================================================================
  // Tracker start holdoff
  logic [TW-1:0] trk_cnt_q;

  always_ff @(posedge core_clk) begin
    if (reset || !trk_en_s) begin
      trk_cnt_q     <= '0;
      tracker_start <= 1'b0;
    end else if (!uvlo_s) begin
      tracker_start <= 1'b1;
    end else if (!opt_b_q[pmic_opt_pkg::TRK_HOLD_BIT]
                 && trk_cnt_q >= TW'(pmic_opt_pkg::TRK_WAIT_US)) begin
      tracker_start <= 1'b1;
    end else if (tick_q && trk_cnt_q < TW'(pmic_opt_pkg::TRK_WAIT_US)) begin
      trk_cnt_q <= trk_cnt_q + TW'(1);
    end
  end

  // ==========================================================================
  // Reset release delay
  rst_state_e    rst_q;
  logic [TW-1:0] rst_cnt_q;
  logic [TW-1:0] rst_lim;

  assign rst_lim = TW'(pmic_opt_pkg::RST_DLY_US[
                   opt_b_q[pmic_opt_pkg::RST_DLY_LSB +: 2]]);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rst_q     <= RST_HOLD;
      rst_cnt_q <= '0;
    end else begin
      case (rst_q)
        RST_HOLD: begin
          rst_cnt_q <= '0;
          if (mon_valid_s) begin
            rst_q <= RST_WAIT;
          end
        end
        RST_WAIT: begin
          if (!mon_valid_s) begin
            rst_q <= RST_HOLD;
          end else if (rst_cnt_q >= rst_lim) begin
            rst_q <= RST_DONE;
          end else if (tick_q) begin
            rst_cnt_q <= rst_cnt_q + TW'(1);
          end
        end
        RST_DONE: begin
          if (!mon_valid_s) begin
            rst_q <= RST_HOLD;
          end
        end
        default: rst_q <= RST_HOLD;
      endcase
    end
  end

  assign reset_out_pin_n = (rst_q == RST_DONE);

  // ==========================================================================
  // Converter soft start
  for (genvar c = 0; c < 2; c++) begin : g_ss
    logic [7:0] us_q;
    logic [7:0] lvl_q;
    logic [7:0] step;

    // Converter 1 uses bits 1:0, converter 2 bits 3:2
    assign step = 8'(pmic_opt_pkg::SS_STEP_US[opt_b_q[2*c +: 2]]);

    always_ff @(posedge core_clk) begin
      if (reset || !conv_enable[c]) begin
        us_q  <= 8'h00;
        lvl_q <= 8'h00;
      end else if (tick_q && lvl_q < 8'(pmic_opt_pkg::SS_STEPS)) begin
        if (us_q >= step - 8'h01) begin
          us_q  <= 8'h00;
          lvl_q <= lvl_q + 8'h01;
        end else begin
          us_q <= us_q + 8'h01;
        end
      end
    end

    assign conv_ss_level[c] = lvl_q;
    assign conv_ss_done[c]  = (lvl_q == 8'(pmic_opt_pkg::SS_STEPS));
  end

endmodule

`default_nettype wire

/* File: testbench/pmic_option_bank_properties.sv */
// Purpose: Concurrent checks on the option bank ports
// Assumes: All checks live in the core clock domain
// Notes:   Bound into every instance of the bank
`timescale 1ns/1ps
`default_nettype none
module pmic_option_bank_properties #(
  parameter int TICK_CYCLES = 50
) (
  input wire logic                 core_clk,
  input wire logic                 reset,
  input wire logic                 serial_select_pin_n,
  input wire logic                 serial_data_out_oe_n,
  input wire pmic_opt_pkg::fault_s raw_fault,
  input wire pmic_opt_pkg::fault_s fault_out,
  input wire logic                 key_unlocked,
  input wire logic                 keyed_write_required,
  input wire logic                 frame_error,
  input wire logic                 write_refused,
  input wire logic                 irq_request,
  input wire logic                 irq_out_pin,
  input wire logic                 irq_out_oe_n,
  input wire logic                 monitor_valid_input,
  input wire logic                 reset_out_pin_n,
  input wire logic [1:0][7:0]      conv_ss_level,
  input wire logic [1:0]           conv_ss_done
);
  localparam int WARN_MIN = 9 * TICK_CYCLES;
  int warn_run_q;
  // ========
  // Run length of raw warning-over input
  always_ff @(posedge core_clk) begin
    if (reset || !raw_fault.core_warn_ov) begin
      warn_run_q <= 0;
    end else if (warn_run_q < 1000000) begin
      warn_run_q <= warn_run_q + 1;
    end
  end
  // ========
  // Properties
  default clocking ck @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_raw_low;
    !raw_fault.overtemp [*5];
  endsequence
  sequence s_valid_low;
    !monitor_valid_input [*5];
  endsequence
  sequence s_step;
    conv_ss_level[1] == 8'($past(conv_ss_level[1]) + 8'h01);
  endsequence
  sequence s_hold;
    $stable(conv_ss_level[1]) [*8];
  endsequence
  AST_SDO_DRIVEN: assert property (!serial_select_pin_n |->
    !serial_data_out_oe_n) else $error("serial output floated in frame");
  AST_IRQ_PUSH_PULL: assert property (irq_out_pin |->
    !irq_out_oe_n && !$past(irq_request)) else $error("irq pin high wrong");
  AST_IRQ_OPEN_DRAIN: assert property (irq_out_oe_n |->
    !irq_out_pin && !$past(irq_request)) else $error("irq release wrong");
  AST_REFUSE_PULSE: assert property (write_refused |=>
    !write_refused) else $error("refusal pulse too long");
  AST_REFUSE_NO_KEY: assert property (write_refused |->
    keyed_write_required && !key_unlocked) else $error("refusal unjustified");
  AST_FRAME_ERR_END: assert property (frame_error |->
    serial_select_pin_n ##1 !frame_error) else $error("frame error timing");
  AST_FAULT_DROP: assert property (s_raw_low |->
    !fault_out.overtemp) else $error("fault held after raw low");
  AST_FAULT_WAIT: assert property ($rose(fault_out.core_warn_ov) |->
    warn_run_q >= WARN_MIN) else $error("warning fault too early");
  AST_RST_HOLD_LOW: assert property (s_valid_low |->
    !reset_out_pin_n) else $error("reset released without valid");
  AST_SS_CEILING: assert property (conv_ss_done[0] |->
    conv_ss_level[0] == 8'h80) else $error("soft start done early");
  AST_SS_PACE: assert property (s_step |=> s_hold)
    else $error("soft start step too fast");
endmodule
bind pmic_option_bank pmic_option_bank_properties #(
  .TICK_CYCLES(TICK_CYCLES)
) props (
  .core_clk(core_clk), .reset(reset),
  .serial_select_pin_n(serial_select_pin_n),
  .serial_data_out_oe_n(serial_data_out_oe_n),
  .raw_fault(raw_fault), .fault_out(fault_out),
  .key_unlocked(key_unlocked), .keyed_write_required(keyed_write_required),
  .frame_error(frame_error), .write_refused(write_refused),
  .irq_request(irq_request), .irq_out_pin(irq_out_pin),
  .irq_out_oe_n(irq_out_oe_n), .monitor_valid_input(monitor_valid_input),
  .reset_out_pin_n(reset_out_pin_n), .conv_ss_level(conv_ss_level),
  .conv_ss_done(conv_ss_done)
);
`default_nettype wire

/* File: testbench/spi_host_model.sv */
// Purpose: Serial host that frames register accesses
// Assumes: Mode 0, 15 ns serial clock, clock idle low between frames
// Notes:   Returns the first 8 bits shifted out of each frame
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic      sclk,
  output logic      sel_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'h0;
    sel_n = 1'h1;
    mosi = 1'h1;
  end
  // ========
  // One frame, caller supplies format and CRC
  task automatic xfer(input logic [31:0] bits, input int n,
                      output logic [7:0] rd);
    #3.3;
    sel_n = 1'h0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = bits[i];
      #7.5 sclk = 1'h1;
      if (i >= n - 8) rd = {rd[6:0], miso};
      #7.5 sclk = 1'h0;
    end
    #7.5 sel_n = 1'h1;
    mosi = ~mosi;
    #200;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the option bank
// Assumes: Time base shortened to 2 core cycles
// Notes:   Serial side driven by the host model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int T = 2;
  localparam logic [9:0] CORE = 10'h163;
  localparam logic [9:0] AON = 10'h164;
  localparam logic [9:0] OPTA = 10'h200;
  localparam logic [9:0] OPTB = 10'h201;
  logic core_clk, reset, sclk, sel_n, mosi, sdo, sdo_oe_n, crc_on;
  logic standby_n, in_deep, deep_exit, key_unlocked, keyed_req, reg4_lin;
  logic reg3_lin, safe_act, safe_pin, crc_mode, frame_error, refused_p;
  logic trk_en, trk_uvlo, trk_start, irq_req, irq_pin, irq_oe_n, mon_valid;
  logic rst_out_n;
  logic [1:0] conv_en, ss_done;
  logic [1:0][7:0] ss_level;
  pmic_opt_pkg::fault_s raw_fault, fault_out;
  int mismatches = 0, samples_checked = 0, ferr = 0, refused = 0;
  spi_host_model host (.sclk(sclk), .sel_n(sel_n), .mosi(mosi), .miso(sdo));
  pmic_option_bank #(.TICK_CYCLES(T)) dut (
    .core_clk(core_clk), .reset(reset), .spi_sclk(sclk),
    .serial_select_pin_n(sel_n), .spi_mosi(mosi), .serial_data_out_pin(sdo),
    .serial_data_out_oe_n(sdo_oe_n), .raw_fault(raw_fault),
    .fault_out(fault_out), .standby_request_pin_n(standby_n),
    .in_deep_low_power(in_deep), .deep_exit_request(deep_exit),
    .key_unlocked(key_unlocked), .keyed_write_required(keyed_req),
    .reg4_linear_mode(reg4_lin), .reg3_linear_mode(reg3_lin),
    .safe_state_active(safe_act), .safe_state_pin(safe_pin),
    .crc_mode(crc_mode), .frame_error(frame_error),
    .write_refused(refused_p), .tracker_enable(trk_en),
    .tracker_supply_uvlo(trk_uvlo), .tracker_start(trk_start),
    .irq_request(irq_req), .irq_out_pin(irq_pin), .irq_out_oe_n(irq_oe_n),
    .monitor_valid_input(mon_valid), .reset_out_pin_n(rst_out_n),
    .conv_enable(conv_en), .conv_ss_level(ss_level), .conv_ss_done(ss_done)
  );
  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (frame_error === 1'h1) ferr++;
    if (refused_p === 1'h1) refused++;
  end
  // ========
  // Shared helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] crc8(logic [23:0] v);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 23; i >= 0; i--)
      c = {c[6:0], 1'h0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  function automatic logic [31:0] frame(logic w, logic [9:0] a,
                                        logic [7:0] d);
    logic [23:0] f;
    f = {w, a, 5'h00, d};
    return crc_on ? {f, crc8(f)} : {8'h00, f};
  endfunction
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.xfer(frame(1'h1, a, d), crc_on ? 32 : 24, r);
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] r;
    host.xfer(frame(1'h0, a, 8'h00), crc_on ? 32 : 24, r);
    host.xfer(frame(1'h0, a, 8'h00), crc_on ? 32 : 24, r);
    chk(r, e);
  endtask
  function automatic logic probe(int k);
    case (k)
      0: return rst_out_n;
      1: return trk_start;
      2: return ss_done[0];
      3: return ss_done[1];
      default: return fault_out[k-4];
    endcase
  endfunction
  task automatic meas(input int k, input int lo, input int hi);
    int n;
    n = 0;
    while (probe(k) !== 1'h1 && n <= hi) begin
      @(negedge core_clk);
      n++;
    end
    chk(n >= lo && n <= hi, 1);
    if (n > hi) wrap_up();
  endtask
  task automatic db(input int k, input logic [9:0] a, input logic [7:0] d,
                    input int us);
    wr(a, d);
    @(negedge core_clk);
    if (us >= 10) begin
      raw_fault[k] = 1'h1;
      repeat (us * T / 2) @(negedge core_clk);
      raw_fault[k] = 1'h0;
      repeat (6) @(negedge core_clk);
      chk(fault_out[k], 1'h0);
    end
    raw_fault[k] = 1'h1;
    meas(4 + k, us * T - T, us * T + T + 6);
    raw_fault[k] = 1'h0;
    repeat (6) @(negedge core_clk);
  endtask
  // ========
  // Scenarios
  task automatic t_options();
    wr(OPTA, 8'hBE);
    rd_chk(OPTA, 8'hB6);
    safe_act = 1'h1;
    in_deep = 1'h1;
    standby_n = 1'h0;
    repeat (6) @(negedge core_clk);
    chk({reg4_lin, reg3_lin, sdo_oe_n, safe_pin, deep_exit}, 5'h1D);
    wr(OPTA, 8'h00);
    repeat (6) @(negedge core_clk);
    chk({reg4_lin, reg3_lin, sdo_oe_n, safe_pin, deep_exit}, 5'h02);
    wr(OPTB, 8'hFF);
    rd_chk(OPTB, 8'hFF);
    wr(10'h165, 8'hA5);
    rd_chk(10'h165, 8'h00);
  endtask
  task automatic t_secure();
    wr(OPTA, 8'h40);
    chk(keyed_req, 1'h1);
    wr(CORE, 8'h55);
    chk(refused, 1);
    rd_chk(CORE, 8'h01);
    key_unlocked = 1'h1;
    wr(CORE, 8'h55);
    rd_chk(CORE, 8'h55);
    wr(OPTA, 8'h01);
    crc_on = 1'h1;
    rd_chk(OPTA, 8'h01);
  endtask
  task automatic t_crc();
    logic [7:0] r;
    chk(crc_mode, 1'h1);
    host.xfer(frame(1'h1, CORE, 8'hAA) ^ 32'h00000001, 32, r);
    host.xfer(frame(1'h1, CORE, 8'hAA) >> 8, 24, r);
    chk(ferr, 2);
    rd_chk(CORE, 8'h55);
    wr(OPTA, 8'h00);
    crc_on = 1'h0;
    host.xfer(frame(1'h1, CORE, 8'hAA) >> 1, 23, r);
    chk(ferr, 3);
  endtask
  task automatic t_irq();
    irq_req = 1'h1;
    repeat (4) @(negedge core_clk);
    chk({irq_pin, irq_oe_n}, 2'h0);
    wr(OPTB, 8'h40);
    irq_req = 1'h0;
    repeat (4) @(negedge core_clk);
    chk({irq_pin, irq_oe_n}, 2'h1);
  endtask
  task automatic t_timers();
    int d[4] = '{0, 1500, 2000, 5000};
    for (int c = 0; c < 4; c++) begin
      wr(OPTB, 8'(c << 4));
      mon_valid = 1'h0;
      repeat (8) @(negedge core_clk);
      mon_valid = 1'h1;
      meas(0, d[c] * T * 4 / 5, d[c] * T * 6 / 5 + 8);
    end
    trk_uvlo = 1'h1;
    trk_en = 1'h1;
    meas(1, 3000 * T - T, 3000 * T + T + 8);
    wr(OPTB, 8'h89);
    trk_en = 1'h0;
    repeat (8) @(negedge core_clk);
    trk_en = 1'h1;
    conv_en = 2'h3;
    repeat (3000 * T + 100) @(negedge core_clk);
    chk(trk_start, 1'h0);
    trk_uvlo = 1'h0;
    meas(1, 0, 8);
    meas(2, 0, 128 * 20 * T + 20 * T + 8);
    chk(ss_level[0], 8'h80);
    meas(3, 128 * 40 * T - 3100 * T - 40 * T, 128 * 40 * T);
  endtask
  initial begin
    int sev[4] = '{1, 5, 10, 25};
    int ot[4] = '{50, 100, 1000, 2500};
    reset = 1'h1;
    raw_fault = 11'h000;
    {standby_n, in_deep, key_unlocked, safe_act, trk_en} = 5'h10;
    {trk_uvlo, irq_req, mon_valid, crc_on} = 4'h0;
    conv_en = 2'h0;
    repeat (10) @(negedge core_clk);
    reset = 1'h0;
    repeat (5) @(negedge core_clk);
    chk({fault_out, rst_out_n, irq_pin, irq_oe_n}, 14'h0002);
    rd_chk(CORE, 8'h00);
    rd_chk(AON, 8'h00);
    rd_chk(OPTA, 8'h00);
    t_options();
    for (int c = 0; c < 4; c++) db(10, CORE, 8'(c << 6), sev[c]);
    db(9, CORE, 8'h30, 100);
    db(8, CORE, 8'h08, 10);
    db(7, CORE, 8'h01, 25);
    db(6, AON, 8'hC0, 25);
    db(5, AON, 8'h20, 50);
    db(3, AON, 8'h04, 25);
    for (int c = 0; c < 4; c++) db(0, AON, 8'(c), ot[c]);
    t_secure();
    t_crc();
    t_irq();
    t_timers();
    wrap_up();
  end
endmodule
`default_nettype wire
